// ==== rtl/lpg_pkg.sv ====
// Package for the line control register bank: offsets, fields, timing.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package lpg_pkg;
    localparam logic [11:0] LPG_OFS_GLOBAL_CTRL = 12'hfe0;
    localparam logic [11:0] LPG_OFS_SEG_SIX     = 12'hfe4;
    localparam logic [11:0] LPG_OFS_SEG_SEVEN   = 12'hfe8;
    localparam logic [11:0] LPG_OFS_SEG_EIGHT   = 12'hfec;
    localparam logic [11:0] LPG_OFS_EQ_SELECT   = 12'hff0;
    localparam logic [11:0] LPG_OFS_STATUS      = 12'hff4;
    localparam logic [7:0]  LPG_RST_VAL         = 8'h00;
    localparam int LPG_BIT_RAIL   = 7;
    localparam int LPG_BIT_AUTO1  = 6;
    localparam int LPG_BIT_RXEDGE = 5;
    localparam int LPG_BIT_TXEDGE = 4;
    localparam int LPG_BIT_POL    = 3;
    localparam int LPG_BIT_GIE    = 1;
    localparam int LPG_BIT_SRST   = 0;
    localparam int LPG_SEG_W      = 7;
    localparam int LPG_SEG_SIGN   = 6;
    localparam int LPG_EQ_W       = 5;
    localparam logic [4:0] LPG_EQ_ARBITRARY = 5'h1f;
    localparam int LPG_CLK_MHZ    = 125;
    localparam int LPG_SRST_HOLD_US = 10;
    // Strictly longer than the hold: one cycle beyond the rounded count
    localparam int LPG_SRST_CYCLES = LPG_SRST_HOLD_US * LPG_CLK_MHZ + 1;
    localparam int LPG_SRST_PULSE  = 16;
    localparam int LPG_CNT_W       = 12;
    typedef enum logic [1:0] {
        LPG_IDLE  = 2'b00,
        LPG_COUNT = 2'b01,
        LPG_RESET = 2'b10,
        LPG_WAIT  = 2'b11
    } lpg_srst_e;
endpackage

// ==== rtl/lpg_seg_mem.sv ====
// Three-entry memory holding pulse-shape segments six to eight.
// Assumes single writer; read data is registered.
module lpg_seg_mem
    import lpg_pkg::*;
#(
    parameter int DEPTH = 3,
    parameter int AW    = 2
) (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 wr_en,
    input  wire logic [AW-1:0]        wr_addr,
    input  wire logic [LPG_SEG_W-1:0] wr_data,
    input  wire logic [AW-1:0]        rd_addr,
    output logic      [LPG_SEG_W-1:0] rd_data,
    output logic      [LPG_SEG_W*DEPTH-1:0] all_q
);
    logic [LPG_SEG_W-1:0] mem_q [DEPTH];
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    mem_q[g] <= LPG_RST_VAL[LPG_SEG_W-1:0];
                end else if (wr_en && wr_addr == AW'(g)) begin
                    mem_q[g] <= wr_data;
                end
            end
            assign all_q[g*LPG_SEG_W +: LPG_SEG_W] = mem_q[g];
        end
    endgenerate
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= LPG_RST_VAL[LPG_SEG_W-1:0];
        end else if (rd_addr < AW'(DEPTH)) begin
            rd_data <= mem_q[rd_addr];
        end else begin
            rd_data <= LPG_RST_VAL[LPG_SEG_W-1:0];
        end
    end
endmodule

// ==== rtl/lpg_global_ctrl.sv ====
// Global control and pulse-shape segment register bank of the line unit.
// Assumes a classic Wishbone master and one 125 MHz clock.
// Contract
// - Arbitrary mode uses segments six to eight as pulse segments 6-8.
// - Each segment is seven-bit signed magnitude, bit 6 the sign.
// - Segment shapes apply only once equalizer select picks arbitrary.
// - Rail select 0 gives dual rail, 1 gives single rail.
// - Auto ones bit makes lost-signal channels transmit all ones.
// - Bypass receive rails update rising when bit 5 is 0, else falling.
// - Bypass transmit rails sampled falling when bit 4 is 0, else rising.
// - Polarity bit 0 means active high data, 1 active low.
// - Global interrupt gate off means no interrupt at all.
// - Interrupt is global gate AND per-source enable AND status.
// - Soft reset bit held above 10 us before device reset starts.
// - Soft reset clears internal circuits, keeps processor registers.
module lpg_global_ctrl
    import lpg_pkg::*;
#(
    parameter int CHANNELS   = 8,
    parameter int SRST_HOLD  = LPG_SRST_CYCLES,
    parameter int SRST_PULSE = LPG_SRST_PULSE
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [11:0]         wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [3:0]          wb_sel_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    output logic                     wb_err_o,
    input  wire logic [CHANNELS-1:0] rx_signal_loss,
    input  wire logic [CHANNELS-1:0] irq_source_status,
    input  wire logic [CHANNELS-1:0] irq_source_enable,
    input  wire logic [CHANNELS-1:0] tx_data_in,
    output logic      [CHANNELS-1:0] tx_data_out,
    output logic      [CHANNELS-1:0] rx_data_polarized,
    input  wire logic [CHANNELS-1:0] rx_data_raw,
    output logic      [LPG_SEG_W-1:0] shape_amplitude_six,
    output logic      [LPG_SEG_W-1:0] shape_amplitude_seven,
    output logic      [LPG_SEG_W-1:0] shape_amplitude_eight,
    output logic                     shape_arbitrary_active,
    output logic                     rail_select,
    output logic                     rx_output_edge_select,
    output logic                     tx_input_edge_select,
    output logic                     line_data_polarity,
    output logic                     irq_o,
    output logic                     internal_reset_b
);
    logic [7:0]            ctrl_q;
    logic [LPG_EQ_W-1:0]   eq_q;
    logic                  ack_q;
    logic                  err_q;
    logic [31:0]           rdat_q;
    logic [LPG_CNT_W-1:0]  cnt_q;
    logic [LPG_CNT_W-1:0]  cnt_d;
    lpg_srst_e             st_q;
    lpg_srst_e             st_d;
    logic [LPG_SEG_W-1:0]  seg_rd;
    logic [LPG_SEG_W*3-1:0] seg_all;
    logic                  loss_q;

    wire req      = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    wire lane0    = wb_sel_i[0];
    wire hit_ctrl = wb_adr_i == LPG_OFS_GLOBAL_CTRL;
    wire hit_s6   = wb_adr_i == LPG_OFS_SEG_SIX;
    wire hit_s7   = wb_adr_i == LPG_OFS_SEG_SEVEN;
    wire hit_s8   = wb_adr_i == LPG_OFS_SEG_EIGHT;
    wire hit_eq   = wb_adr_i == LPG_OFS_EQ_SELECT;
    wire hit_st   = wb_adr_i == LPG_OFS_STATUS;
    wire hit_seg  = hit_s6 || hit_s7 || hit_s8;
    wire hit_any  = hit_ctrl || hit_seg || hit_eq || hit_st;
    wire wr       = req && wb_we_i && hit_any && lane0;
    wire [1:0] seg_idx = hit_s6 ? 2'd0 : (hit_s7 ? 2'd1 : 2'd2);
    wire seg_wr   = wr && hit_seg;
    wire srst_bit = ctrl_q[LPG_BIT_SRST];
    wire arb_mode = eq_q == LPG_EQ_ARBITRARY;
    wire global_irq_gate      = ctrl_q[LPG_BIT_GIE];
    wire in_reset = st_q == LPG_RESET;
    wire auto_ones = ctrl_q[LPG_BIT_AUTO1];
    wire irq_any  = |(irq_source_status & irq_source_enable);

    // Seven full bits stored for every segment, sign in bit 6
    lpg_seg_mem #(.DEPTH(3), .AW(2)) u_seg (
        .clk     (clk),
        .rst_b   (rst_b),
        .wr_en   (seg_wr),
        .wr_addr (seg_idx),
        .wr_data (wb_dat_i[LPG_SEG_W-1:0]),
        .rd_addr (seg_idx),
        .rd_data (seg_rd),
        .all_q   (seg_all)
    );

    // Registers answer one cycle after the request; soft reset leaves them
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= LPG_RST_VAL;
            eq_q   <= LPG_RST_VAL[LPG_EQ_W-1:0];
        end else begin
            if (wr && hit_ctrl) begin
                ctrl_q <= wb_dat_i[7:0] & 8'hfb;
            end
            if (wr && hit_eq) begin
                eq_q <= wb_dat_i[LPG_EQ_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= req && hit_any;
            err_q <= req && !hit_any;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdat_q <= 32'h0;
        end else if (req) begin
            rdat_q <= 32'h0;
            if (hit_ctrl) rdat_q[7:0] <= ctrl_q;
            if (hit_eq) rdat_q[LPG_EQ_W-1:0] <= eq_q;
            // Status also shows whether any channel has lost its signal
            if (hit_st) rdat_q[2:0] <= {loss_q, irq_o, in_reset};
        end
    end

    // Segment data arrive from the memory's own register in the ack cycle
    always_comb begin
        wb_dat_o = rdat_q;
        if (hit_seg) begin
            wb_dat_o = {25'h0, seg_rd};
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;

    // Soft reset: count a continuous hold, then pulse the internal reset
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            LPG_IDLE: begin
                cnt_d = '0;
                if (srst_bit) st_d = LPG_COUNT;
            end
            LPG_COUNT: begin
                if (!srst_bit) begin
                    st_d  = LPG_IDLE;
                    cnt_d = '0;
                end else if (cnt_q >= LPG_CNT_W'(SRST_HOLD - 1)) begin
                    st_d  = LPG_RESET;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            LPG_RESET: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q >= LPG_CNT_W'(SRST_PULSE - 1)) st_d = LPG_WAIT;
            end
            LPG_WAIT: begin
                // One reset per hold; bit must return to 0 first
                cnt_d = '0;
                if (!srst_bit) st_d = LPG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q  <= LPG_IDLE;
            cnt_q <= '0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end
    assign internal_reset_b = !in_reset;

    // Internal state, cleared by both resets
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loss_q <= 1'b0;
        end else if (in_reset) begin
            loss_q <= 1'b0;
        end else begin
            loss_q <= |rx_signal_loss;
        end
    end

    assign rail_select           = ctrl_q[LPG_BIT_RAIL];
    assign rx_output_edge_select = ctrl_q[LPG_BIT_RXEDGE];
    assign tx_input_edge_select  = ctrl_q[LPG_BIT_TXEDGE];
    assign line_data_polarity    = ctrl_q[LPG_BIT_POL];
    assign shape_arbitrary_active = arb_mode;
    // Zero amplitude outside arbitrary mode so the shaper sees no stale data
    assign shape_amplitude_six   = arb_mode ? seg_all[6:0]   : '0;
    assign shape_amplitude_seven = arb_mode ? seg_all[13:7]  : '0;
    assign shape_amplitude_eight = arb_mode ? seg_all[20:14] : '0;

    // Per-channel data flops; polarity inverts both directions
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_chan
            // Ones win over polarity so a dead line still sees marks
            wire send_ones = auto_ones && rx_signal_loss[c];
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    tx_data_out[c]       <= 1'b0;
                    rx_data_polarized[c] <= 1'b0;
                end else if (in_reset) begin
                    tx_data_out[c]       <= 1'b0;
                    rx_data_polarized[c] <= 1'b0;
                end else begin
                    tx_data_out[c] <= send_ones ||
                        (tx_data_in[c] ^ line_data_polarity);
                    rx_data_polarized[c] <=
                        rx_data_raw[c] ^ line_data_polarity;
                end
            end
        end
    endgenerate

    // One flop, so the interrupt follows the enables a cycle late
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_o <= 1'b0;
        end else if (in_reset) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= global_irq_gate && irq_any;
        end
    end

    a_irq_gate_off: assert property (@(posedge clk) disable iff (!rst_b)
        !$past(global_irq_gate) |-> !irq_o)
        else $error("Interrupt raised with global gate off");
    a_irq_and: assert property (@(posedge clk) disable iff (!rst_b)
        $past(!in_reset) |-> irq_o == ($past(global_irq_gate)
            && |$past(irq_source_status & irq_source_enable)))
        else $error("Interrupt is not the AND of enables");
    a_srst_early: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(srst_bit) |-> internal_reset_b [*8])
        else $error("Soft reset fired before hold time");
    a_srst_restart: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q == LPG_COUNT && !srst_bit) |=> cnt_q == '0)
        else $error("Hold counter did not restart");
    a_srst_keep: assert property (@(posedge clk) disable iff (!rst_b)
        in_reset && !wr |=> $stable(ctrl_q) && $stable(eq_q))
        else $error("Soft reset disturbed registers");
    a_auto_ones: assert property (@(posedge clk) disable iff (!rst_b)
        (!in_reset && ctrl_q[LPG_BIT_AUTO1] && rx_signal_loss[0])
        |=> tx_data_out[0])
        else $error("All ones not sent on signal loss");
    a_polarity: assert property (@(posedge clk) disable iff (!rst_b)
        !in_reset |=> rx_data_polarized ==
            ($past(rx_data_raw) ^ {CHANNELS{$past(line_data_polarity)}}))
        else $error("Receive polarity wrong");
    a_seg_gate: assert property (@(posedge clk) disable iff (!rst_b)
        !arb_mode |-> shape_amplitude_seven == '0)
        else $error("Segment shape applied outside arbitrary mode");
    a_rail_follow: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && hit_ctrl) |=> rail_select == $past(wb_dat_i[LPG_BIT_RAIL]))
        else $error("Rail select not taken from write");
    a_seg_full: assert property (@(posedge clk) disable iff (!rst_b)
        (seg_wr && hit_s8) |=> seg_all[20:14] == $past(wb_dat_i[6:0]))
        else $error("Segment eight not a full seven-bit field");
    a_seg_seven: assert property (@(posedge clk) disable iff (!rst_b)
        (seg_wr && hit_s7) |=> seg_all[13:7] == $past(wb_dat_i[6:0]))
        else $error("Segment seven not a full seven-bit field");
    a_seg_sign: assert property (@(posedge clk) disable iff (!rst_b)
        (seg_wr && hit_s6) |=> seg_all[LPG_SEG_SIGN] ==
            $past(wb_dat_i[LPG_SEG_SIGN]))
        else $error("Segment sign bit not stored");
    a_shape_six: assert property (@(posedge clk) disable iff (!rst_b)
        arb_mode |-> shape_amplitude_six == seg_all[LPG_SEG_W-1:0])
        else $error("Segment six not applied in arbitrary mode");
    a_eq_write: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && hit_eq) |=> shape_arbitrary_active ==
            ($past(wb_dat_i[LPG_EQ_W-1:0]) == LPG_EQ_ARBITRARY))
        else $error("Arbitrary flag does not follow the select write");
    a_edge_follow: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && hit_ctrl) |=> tx_input_edge_select ==
            $past(wb_dat_i[LPG_BIT_TXEDGE]) && rx_output_edge_select ==
            $past(wb_dat_i[LPG_BIT_RXEDGE]))
        else $error("Edge selects not taken from write");
    a_plain_data: assert property (@(posedge clk) disable iff (!rst_b)
        (!in_reset && !auto_ones) |=> tx_data_out ==
            ($past(tx_data_in) ^ {CHANNELS{$past(line_data_polarity)}}))
        else $error("Transmit polarity wrong");

    // Bus side: one answer per request, taken while the master still holds
    sequence s_bus_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence s_bus_answered;
        (wb_ack_o ^ wb_err_o) ##1 (!wb_ack_o && !wb_err_o);
    endsequence
    a_bus_answer: assert property (@(posedge clk) disable iff (!rst_b)
        s_bus_taken |=> s_bus_answered)
        else $error("Bus request not answered in one cycle");
    a_bus_unmapped: assert property (@(posedge clk) disable iff (!rst_b)
        s_bus_taken |=> wb_err_o == !$past(hit_any))
        else $error("Error answer does not match address decode");

    // Soft reset steps: a full hold, a pulse of fixed length, then rearm
    sequence s_hold_done;
        st_q == LPG_COUNT && srst_bit
            && cnt_q >= LPG_CNT_W'(SRST_HOLD - 1);
    endsequence
    sequence s_pulse_begins;
        !internal_reset_b && cnt_q == '0;
    endsequence
    a_srst_start: assert property (@(posedge clk) disable iff (!rst_b)
        s_hold_done |=> s_pulse_begins)
        else $error("Soft reset did not start after the hold");
    a_srst_source: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(internal_reset_b) |->
            $past(st_q) == LPG_COUNT && $past(srst_bit))
        else $error("Soft reset started without a full hold");
    a_srst_length: assert property (@(posedge clk) disable iff (!rst_b)
        in_reset |-> cnt_q < LPG_CNT_W'(SRST_PULSE))
        else $error("Soft reset pulse too long");
    a_srst_once: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == LPG_WAIT |-> internal_reset_b)
        else $error("Soft reset repeated without rearm");
    a_idle_count: assert property (@(posedge clk) disable iff (!rst_b)
        st_q == LPG_IDLE |-> cnt_q == '0)
        else $error("Hold counter not clear while idle");
    a_loss_clear: assert property (@(posedge clk) disable iff (!rst_b)
        in_reset |=> !loss_q)
        else $error("Soft reset left signal loss state");
    a_seg_kept: assert property (@(posedge clk) disable iff (!rst_b)
        in_reset && !seg_wr |=> $stable(seg_all))
        else $error("Soft reset disturbed segment registers");
endmodule

// ==== test/test_liu_pulse_shape_global_ctrl.sv ====
// Bench for the line control register bank: Wishbone tasks, port checks.
// Assumes the register bank alone, one 125 MHz clock, shortened reset hold.
module test_liu_pulse_shape_global_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import lpg_pkg::*;
    localparam int HOLD  = 8;
    localparam int PULSE = 2;
    logic        clk, rst_b, cyc, stb, we, ack, err, arb, rail;
    logic        rxe, txe, pol, irq, int_rst_b;
    logic [11:0] adr;
    logic [31:0] dat, q;
    logic [3:0]  sel;
    logic [7:0]  loss, st, en, txi, txo, rxp, rxr;
    logic [6:0]  s6, s7, s8;
    int          errors, checks, n;
    lpg_global_ctrl #(.CHANNELS(8), .SRST_HOLD(HOLD), .SRST_PULSE(PULSE)) DUT (
        .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
        .wb_dat_o(q), .wb_ack_o(ack), .wb_err_o(err),
        .rx_signal_loss(loss), .irq_source_status(st),
        .irq_source_enable(en), .tx_data_in(txi), .tx_data_out(txo),
        .rx_data_polarized(rxp), .rx_data_raw(rxr),
        .shape_amplitude_six(s6), .shape_amplitude_seven(s7),
        .shape_amplitude_eight(s8), .shape_arbitrary_active(arb),
        .rail_select(rail), .rx_output_edge_select(rxe),
        .tx_input_edge_select(txe), .line_data_polarity(pol),
        .irq_o(irq), .internal_reset_b(int_rst_b));
    always #4 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Holds the request until ack or err is sampled high at a rising edge
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic e);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && err !== 1'b1 && k < 40);
        if (k >= 40) chk("bus answer", 1, 0);
        rd = q;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        bus(1'b1, a, {24'h0, d}, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        bus(1'b0, a, 32'h0, r, e);
        chk("read data", x, r);
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Far beyond the hundred or so cycles that the sequence needs
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
    initial begin
        logic [31:0] r;
        logic        e;
        clk = 0; rst_b = 0; cyc = 0; stb = 0; we = 0; adr = 12'h0;
        dat = 32'h0; sel = 4'hf; loss = 8'h00; st = 8'h00; en = 8'h00;
        txi = 8'h00; rxr = 8'h00; errors = 0; checks = 0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rd(LPG_OFS_GLOBAL_CTRL, 32'h0);
        rd(LPG_OFS_SEG_SIX, 32'h0);
        rd(LPG_OFS_SEG_SEVEN, 32'h0);
        rd(LPG_OFS_SEG_EIGHT, 32'h0);
        rd(LPG_OFS_EQ_SELECT, 32'h0);
        chk("soft reset idle", 1, int_rst_b);
        wr(LPG_OFS_GLOBAL_CTRL, 8'hfe);
        rd(LPG_OFS_GLOBAL_CTRL, 32'hfa);
        chk("mode bits", 4'hf, {rail, rxe, txe, pol});
        wr(LPG_OFS_SEG_SIX, 8'hff);
        wr(LPG_OFS_SEG_SEVEN, 8'h40);
        wr(LPG_OFS_SEG_EIGHT, 8'h3f);
        rd(LPG_OFS_SEG_SIX, 32'h7f);
        rd(LPG_OFS_SEG_SEVEN, 32'h40);
        rd(LPG_OFS_SEG_EIGHT, 32'h3f);
        tick(1);
        chk("shape off", 0, {arb, s6, s7, s8});
        wr(LPG_OFS_EQ_SELECT, LPG_EQ_ARBITRARY);
        tick(1);
        chk("shape on", {1'b1, 21'h1fe03f}, {arb, s6, s7, s8});
        wr(LPG_OFS_EQ_SELECT, 8'h1e);
        tick(1);
        chk("shape near code", 0, {arb, s6, s7, s8});
        @(posedge clk);
        loss <= 8'h0f;
        txi <= 8'h33;
        rxr <= 8'h5a;
        tick(3);
        chk("tx ones inverted", 8'hcf, txo);
        chk("rx inverted", 8'ha5, rxp);
        wr(LPG_OFS_GLOBAL_CTRL, 8'h00);
        st <= 8'h05;
        en <= 8'h04;
        tick(3);
        chk("tx plain", 8'h33, txo);
        chk("rx plain", 8'h5a, rxp);
        chk("irq gated", 0, irq);
        wr(LPG_OFS_GLOBAL_CTRL, 8'h02);
        tick(3);
        chk("irq on", 1, irq);
        rd(LPG_OFS_STATUS, 32'h6);
        en <= 8'h02;
        tick(3);
        chk("irq source off", 0, irq);
        bus(1'b1, 12'h100, 32'h0, r, e);
        chk("unmapped write err", 1, e);
        bus(1'b0, 12'hffc, 32'h0, r, e);
        chk("unmapped read err", 1, e);
        // An early drop must discard the partial count
        wr(LPG_OFS_GLOBAL_CTRL, 8'h83);
        wr(LPG_OFS_GLOBAL_CTRL, 8'h82);
        wr(LPG_OFS_GLOBAL_CTRL, 8'h83);
        n = 0;
        while (int_rst_b !== 1'b0 && n < 4 * HOLD) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("reset delay", 1, n >= HOLD - 1 && n <= HOLD + 3);
        tick(PULSE + 2);
        chk("reset over", 1, int_rst_b);
        rd(LPG_OFS_GLOBAL_CTRL, 32'h83);
        rd(LPG_OFS_SEG_SIX, 32'h7f);
        wr(LPG_OFS_GLOBAL_CTRL, 8'h00);
        tally_and_finish();
    end
endmodule
